// ### irc_pkg.sv
package irc_pkg;

    // ****************************************************************
    // register indices (byte address is four times the index)
    // ****************************************************************
    localparam logic [5:0] IDX_EDGE_STATUS = 6'h01;
    localparam logic [5:0] IDX_CAPTURE_CONTROL = 6'h02;
    localparam logic [5:0] IDX_CAPTURE_LOW = 6'h03;
    localparam logic [5:0] IDX_CAPTURE_HIGH = 6'h04;

    // ****************************************************************
    // field positions
    // ****************************************************************
    localparam int STAT_REF_BIT = 0;
    localparam int STAT_RISE_BIT = 1;
    localparam int STAT_FALL_BIT = 2;
    localparam int CTRL_STOP_BIT = 6;
    localparam int CTRL_EDGE_LSB = 4;
    localparam int CTRL_FILT_LSB = 2;
    localparam int CTRL_RATE_LSB = 0;

    // ****************************************************************
    // reset values and counter maximum
    // ****************************************************************
    localparam logic [6:0] CTRL_RESET = 7'h40;
    localparam logic [15:0] CAPTURE_RESET = 16'h0000;
    localparam logic [15:0] COUNT_MAX = 16'hffff;

    // ****************************************************************
    // edge select codes
    // ****************************************************************
    localparam logic [1:0] EDGE_NONE = 2'h0;
    localparam logic [1:0] EDGE_RISE = 2'h1;
    localparam logic [1:0] EDGE_FALL = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;

    // ****************************************************************
    // filter off code and lengths in system clocks, and rate divisors minus one
    // ****************************************************************
    localparam logic [1:0] FILT_OFF = 2'h0;
    localparam logic [4:0] FILT_LEN_1 = 5'h02;
    localparam logic [4:0] FILT_LEN_2 = 5'h08;
    localparam logic [4:0] FILT_LEN_3 = 5'h10;
    localparam logic [4:0] DIV32_M1 = 5'h1f;
    localparam logic [4:0] DIV4_M1 = 5'h03;
    localparam logic [4:0] DIV8_M1 = 5'h07;
    localparam logic [4:0] DIV16_M1 = 5'h0f;

    // ****************************************************************
    // apb carriers
    // ****************************************************************
    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } irc_apb_req_type;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } irc_apb_rsp_type;

endpackage

// ### irc_glitch_filter.sv
`timescale 1ns/1ps
`default_nettype none

module irc_glitch_filter (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ir_pin,
    input wire logic [1:0] filter_select,
    output logic ir_clean
);

    // ****************************************************************
    // three-stage pin synchroniser
    // ****************************************************************
    logic sync1_reg;
    logic sync2_reg;
    logic sync3_reg;
    logic clean_reg;
    logic [4:0] cnt_reg;
    logic [4:0] len;
    logic settled;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1_reg <= 1'b0;
            sync2_reg <= 1'b0;
            sync3_reg <= 1'b0;
        end else begin
            sync1_reg <= ir_pin;
            sync2_reg <= sync1_reg;
            sync3_reg <= sync2_reg;
        end
    end

    assign settled = (sync2_reg == sync3_reg);

    always_comb begin
        case (filter_select)
            2'h1: len = irc_pkg::FILT_LEN_1;
            2'h2: len = irc_pkg::FILT_LEN_2;
            default: len = irc_pkg::FILT_LEN_3;
        endcase
    end

    // ****************************************************************
    // pulse rejection
    // ****************************************************************
    // hold counter: output takes the settled input once the count reaches len minus two
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clean_reg <= 1'b0;
            cnt_reg <= 5'h00;
        end else if (!settled || sync3_reg == clean_reg) begin
            cnt_reg <= 5'h00;
        end else if (filter_select == irc_pkg::FILT_OFF || cnt_reg == len - 5'h02) begin
            clean_reg <= sync3_reg;
            cnt_reg <= 5'h00;
        end else begin
            cnt_reg <= cnt_reg + 5'h01;
        end
    end

    assign ir_clean = clean_reg;

    a_filter_len: assert property (@(posedge clk) disable iff (!rst_n)
        ($changed(clean_reg) && $past(filter_select) != irc_pkg::FILT_OFF)
        |-> $past(cnt_reg) == $past(len) - 5'h02)
        else $error("filtered input changed before its hold time");

endmodule

`default_nettype wire

// ### irc_edge_capture.sv
// Function
// - capture low byte holds bits 7-0, high byte holds bits 15-8
// - reference bit 0 clear: value is time since previous interrupt
// - reference bit 0 set: value is time since last counter overflow
// - interrupt flags stay set until software clears them
// - pending edge of one polarity survives an opposite-polarity event
// - newer same-polarity edge replaces the older pending event
// - both pending: a further interrupt follows servicing the first
// - status holds a 1 for each edge type pending
// - control bit 6 halts and clears the capture timer, reset value 1
// - control bits 5:4 select none, rising, falling or both edges
// - control bits 3:2 select filter off or 2, 8, 16 clock rejection
// - control bits 1:0 select counter clock divide 32, 4, 8, 16
// - capture counter runs only from divided system clock
// - capture bytes are read-only and reset to zero
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none

module irc_edge_capture (
    input wire logic clk,
    input wire logic rst_n,
    input wire irc_pkg::irc_apb_req_type apb_req,
    output var irc_pkg::irc_apb_rsp_type apb_rsp,
    input wire logic ir_in,
    output logic ir_irq,
    output logic ir_irq_pulse
);

    // ****************************************************************
    // declarations
    // ****************************************************************
    logic [6:0] ctrl_reg;
    logic ref_sel_reg;
    logic pend_rise_reg;
    logic pend_fall_reg;
    logic [15:0] cap_reg;
    logic [15:0] count_reg;
    logic [4:0] pre_cnt_reg;
    logic clean_d_reg;
    logic irq_pulse_reg;
    logic ir_clean;
    logic stop;
    logic [1:0] edge_sel;
    logic [1:0] filt_sel;
    logic [1:0] rate_sel;
    logic [4:0] div_m1;
    logic tick;
    logic cap_rise;
    logic cap_fall;
    logic capture;
    logic access;
    logic addr_ok;
    logic [5:0] idx;
    logic wr_stat;
    logic wr_ctrl;
    logic clr_rise;
    logic clr_fall;
    logic [7:0] rd_byte;

    assign stop = ctrl_reg[irc_pkg::CTRL_STOP_BIT];
    assign edge_sel = ctrl_reg[irc_pkg::CTRL_EDGE_LSB +: 2];
    assign filt_sel = ctrl_reg[irc_pkg::CTRL_FILT_LSB +: 2];
    assign rate_sel = ctrl_reg[irc_pkg::CTRL_RATE_LSB +: 2];

    // ****************************************************************
    // apb decode
    // ****************************************************************
    assign idx = apb_req.paddr[7:2];
    assign access = apb_req.psel && apb_req.penable;
    assign addr_ok = (apb_req.paddr[1:0] == 2'h0)
        && (idx == irc_pkg::IDX_EDGE_STATUS || idx == irc_pkg::IDX_CAPTURE_CONTROL
        || idx == irc_pkg::IDX_CAPTURE_LOW || idx == irc_pkg::IDX_CAPTURE_HIGH);
    assign wr_stat = access && apb_req.pwrite && addr_ok && idx == irc_pkg::IDX_EDGE_STATUS;
    assign wr_ctrl = access && apb_req.pwrite && addr_ok
        && idx == irc_pkg::IDX_CAPTURE_CONTROL;
    assign clr_rise = wr_stat && apb_req.pwdata[irc_pkg::STAT_RISE_BIT];
    assign clr_fall = wr_stat && apb_req.pwdata[irc_pkg::STAT_FALL_BIT];

    // ****************************************************************
    // input filter
    // ****************************************************************
    irc_glitch_filter u_filter (
        .clk(clk),
        .rst_n(rst_n),
        .ir_pin(ir_in),
        .filter_select(filt_sel),
        .ir_clean(ir_clean)
    );

    // ****************************************************************
    // control and status registers
    // ****************************************************************
    // halt bit resets to one
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ctrl_reg <= irc_pkg::CTRL_RESET;
        end else if (wr_ctrl) begin
            ctrl_reg <= apb_req.pwdata[6:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ref_sel_reg <= 1'b0;
        end else if (wr_stat) begin
            ref_sel_reg <= apb_req.pwdata[irc_pkg::STAT_REF_BIT];
        end
    end

    // ****************************************************************
    // prescaler and capture counter
    // ****************************************************************
    // rate divisor select
    always_comb begin
        case (rate_sel)
            2'h1: div_m1 = irc_pkg::DIV4_M1;
            2'h2: div_m1 = irc_pkg::DIV8_M1;
            2'h3: div_m1 = irc_pkg::DIV16_M1;
            default: div_m1 = irc_pkg::DIV32_M1;
        endcase
    end

    assign tick = !stop && pre_cnt_reg == div_m1;

    always_ff @(posedge clk) begin
        if (!rst_n || stop || tick) begin
            pre_cnt_reg <= 5'h00;
        end else begin
            pre_cnt_reg <= pre_cnt_reg + 5'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            count_reg <= 16'h0000;
        end else if (stop) begin
            count_reg <= 16'h0000;
        end else if (capture && !ref_sel_reg) begin
            count_reg <= {15'h0000, tick};
        end else if (tick) begin
            count_reg <= count_reg + 16'h0001;
        end
    end

    // ****************************************************************
    // edge detection and capture
    // ****************************************************************
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            clean_d_reg <= 1'b0;
        end else begin
            clean_d_reg <= ir_clean;
        end
    end

    assign cap_rise = !stop && ir_clean && !clean_d_reg && edge_sel[0];
    assign cap_fall = !stop && !ir_clean && clean_d_reg && edge_sel[1];
    assign capture = cap_rise || cap_fall;

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cap_reg <= irc_pkg::CAPTURE_RESET;
        end else if (capture) begin
            cap_reg <= count_reg;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_rise_reg <= 1'b0;
        end else if (cap_rise) begin
            pend_rise_reg <= 1'b1;
        end else if (clr_rise) begin
            pend_rise_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pend_fall_reg <= 1'b0;
        end else if (cap_fall) begin
            pend_fall_reg <= 1'b1;
        end else if (clr_fall) begin
            pend_fall_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            irq_pulse_reg <= 1'b0;
        end else begin
            irq_pulse_reg <= capture
                || (clr_rise && pend_rise_reg && pend_fall_reg && !clr_fall)
                || (clr_fall && pend_fall_reg && pend_rise_reg && !clr_rise);
        end
    end

    assign ir_irq = pend_rise_reg || pend_fall_reg;
    assign ir_irq_pulse = irq_pulse_reg;

    // ****************************************************************
    // read mux
    // ****************************************************************
    always_comb begin
        case (idx)
            irc_pkg::IDX_EDGE_STATUS: rd_byte = {5'h00, pend_fall_reg, pend_rise_reg,
                ref_sel_reg};
            irc_pkg::IDX_CAPTURE_CONTROL: rd_byte = {1'b0, ctrl_reg};
            irc_pkg::IDX_CAPTURE_LOW: rd_byte = cap_reg[7:0];
            irc_pkg::IDX_CAPTURE_HIGH: rd_byte = cap_reg[15:8];
            default: rd_byte = 8'h00;
        endcase
    end

    always_comb begin
        apb_rsp.pready = 1'b1;
        apb_rsp.pslverr = access && !addr_ok;
        apb_rsp.prdata = (addr_ok && !apb_req.pwrite) ? {24'h000000, rd_byte} : 32'h00000000;
    end

    // ****************************************************************
    // assertions
    // ****************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_capture_latch: assert property (capture |=> cap_reg == $past(count_reg))
        else $error("capture did not latch counter");

    a_rel_restart: assert property ((capture && !ref_sel_reg) |=> count_reg <= 16'h0001)
        else $error("counter not restarted on interrupt");

    a_ovf_reference: assert property ((capture && ref_sel_reg && !tick && !stop)
        |=> count_reg == $past(count_reg))
        else $error("overflow mode counter disturbed by capture");

    a_wrap_zero: assert property ((tick && count_reg == irc_pkg::COUNT_MAX
        && !capture) |=> count_reg == 16'h0000)
        else $error("counter did not wrap");

    a_flag_hold: assert property ((pend_rise_reg && !clr_rise) |=> pend_rise_reg)
        else $error("rising flag lost without clear");

    a_pend_keep: assert property ((pend_fall_reg && cap_rise && !clr_fall)
        |=> pend_fall_reg && pend_rise_reg)
        else $error("falling flag lost on rising event");

    a_second_irq: assert property ((clr_rise && pend_rise_reg && pend_fall_reg
        && !clr_fall && !capture) |=> irq_pulse_reg && ir_irq ##1 !irq_pulse_reg)
        else $error("no further interrupt for remaining flag");

    a_stop_clear: assert property (stop [*2] |-> count_reg == 16'h0000 && !tick)
        else $error("halted timer not held at zero");

    a_rate_tick: assert property (tick |-> pre_cnt_reg == div_m1
        && $past(pre_cnt_reg) == div_m1 - 5'h01 || $past(stop) || $past(wr_ctrl))
        else $error("tick at wrong divisor");

    a_edge_none: assert property (edge_sel == irc_pkg::EDGE_NONE |-> !capture)
        else $error("capture with edges disabled");

    a_cap_readonly: assert property ((access && apb_req.pwrite && !capture)
        |=> $stable(cap_reg))
        else $error("capture register changed by write");

    a_low_byte: assert property ((access && addr_ok && !apb_req.pwrite
        && idx == irc_pkg::IDX_CAPTURE_LOW) |-> apb_rsp.prdata[7:0] == cap_reg[7:0])
        else $error("low capture byte misplaced");

    a_high_byte: assert property ((access && addr_ok && !apb_req.pwrite
        && idx == irc_pkg::IDX_CAPTURE_HIGH) |-> apb_rsp.prdata == {24'h000000, cap_reg[15:8]})
        else $error("high capture byte misplaced");

    a_same_overwrite: assert property ((cap_fall && pend_fall_reg)
        |=> pend_fall_reg && cap_reg == $past(count_reg))
        else $error("newer falling event did not replace older");

    a_status_read: assert property ((access && addr_ok && !apb_req.pwrite
        && idx == irc_pkg::IDX_EDGE_STATUS)
        |-> apb_rsp.prdata[irc_pkg::STAT_RISE_BIT] == pend_rise_reg
        && apb_rsp.prdata[irc_pkg::STAT_FALL_BIT] == pend_fall_reg)
        else $error("status flags not visible");

    a_rise_set_wins: assert property ((cap_rise && clr_rise) |=> pend_rise_reg)
        else $error("rising clear beat a new event");

    a_fall_set_wins: assert property ((cap_fall && clr_fall) |=> pend_fall_reg)
        else $error("falling clear beat a new event");

    a_stop_ignore: assert property (stop |-> !capture)
        else $error("capture taken while halted");

    a_capture_pulse: assert property (capture |=> irq_pulse_reg && ir_irq)
        else $error("capture raised no interrupt");

    a_ctrl_write: assert property (wr_ctrl
        |=> ctrl_reg == $past(apb_req.pwdata[6:0]))
        else $error("control write not taken");

    a_ref_write: assert property (wr_stat
        |=> ref_sel_reg == $past(apb_req.pwdata[irc_pkg::STAT_REF_BIT]))
        else $error("reference select write not taken");

    a_prescale_hold: assert property (stop |=> pre_cnt_reg == 5'h00)
        else $error("prescaler runs while halted");

    a_rise_only: assert property (edge_sel == irc_pkg::EDGE_RISE |-> !cap_fall)
        else $error("falling capture in rising-only mode");

    a_fall_only: assert property (edge_sel == irc_pkg::EDGE_FALL |-> !cap_rise)
        else $error("rising capture in falling-only mode");

    a_ovf_count: assert property ((tick && !(capture && !ref_sel_reg))
        |=> count_reg == $past(count_reg) + 16'h0001)
        else $error("counter skipped a tick");

    // ****************************************************************
    // cover points
    // ****************************************************************
    c_both_pending: cover property (pend_rise_reg && pend_fall_reg);
    c_ovf_capture: cover property (capture && ref_sel_reg);
    c_wrap: cover property (tick && count_reg == irc_pkg::COUNT_MAX);
    c_second_irq: cover property (clr_rise && pend_fall_reg ##1 irq_pulse_reg);
    c_fall_only: cover property (cap_fall && edge_sel == irc_pkg::EDGE_FALL);

endmodule

`default_nettype wire

// ### irc_ir_source.sv
`timescale 1ns/1ps
`default_nettype none

// ****************************************************************
// receiver model: output moves only just after a clock edge
// ****************************************************************
module irc_ir_source (
    input wire logic clk,
    output logic ir_out
);
    initial ir_out = 1'b0;

    task automatic drive(input logic lvl);
        @(posedge clk);
        ir_out <= lvl;
    endtask

    // high for width clocks, then back to idle low
    task automatic pulse(input int width);
        drive(1'b1);
        repeat (width) @(posedge clk);
        ir_out <= 1'b0;
    endtask
endmodule

`default_nettype wire

// ### irc_edge_capture_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module irc_edge_capture_tb_top;
    // ****************************************************************
    // clock, reset and design
    // ****************************************************************
    typedef struct packed {logic loose; logic [41:0] v;} irc_exp_type;
    localparam logic [5:0] ST = irc_pkg::IDX_EDGE_STATUS;
    localparam logic [5:0] CT = irc_pkg::IDX_CAPTURE_CONTROL;
    localparam logic [5:0] LO = irc_pkg::IDX_CAPTURE_LOW;
    localparam logic [5:0] HI = irc_pkg::IDX_CAPTURE_HIGH;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    irc_pkg::irc_apb_req_type req;
    irc_pkg::irc_apb_rsp_type rsp;
    logic ir_wire;
    logic irq;
    logic irq_pulse;
    int bad_count = 0;
    int n_compared = 0;
    logic [7:0] pulses = 8'h00;
    logic [7:0] exp_pulses = 8'h00;
    logic exp_irq = 1'b0;
    logic [31:0] seed = 32'h7;
    irc_exp_type exp_q[$];

    always #12.5 clk = ~clk;

    irc_edge_capture irc_edge_capture_i (.clk(clk), .rst_n(rst_n), .apb_req(req),
        .apb_rsp(rsp), .ir_in(ir_wire), .ir_irq(irq), .ir_irq_pulse(irq_pulse));
    irc_ir_source irc_ir_source_i (.clk(clk), .ir_out(ir_wire));

    always @(posedge clk) begin
        if (irq_pulse === 1'b1) begin
            pulses <= pulses + 8'h01;
        end
    end

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [31:0] xorshift();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    task automatic stop_test();
        if (bad_count == 0 && n_compared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic fail(input string msg);
        bad_count++;
        $display("mismatch at %0t: %s", $time, msg);
    endtask

    // read result: pulse count, error, irq level and data, low byte maybe +-1
    task automatic check_read(input irc_exp_type e, input logic [41:0] got);
        logic [7:0] d;
        logic ok;
        d = got[7:0] - e.v[7:0] + 8'h01;
        ok = (got[41:8] === e.v[41:8]) && !$isunknown(got[7:0])
            && (e.loose ? d <= 8'h02 : d == 8'h01);
        n_compared++;
        if (ok !== 1'b1) begin
            fail($sformatf("read got %h expected %h", got, e.v));
        end
    endtask

    always @(posedge clk) begin
        if (req.psel && req.penable && rsp.pready === 1'b1 && !req.pwrite) begin
            if (exp_q.size() == 0) begin
                fail("read with no expectation");
            end else begin
                check_read(exp_q.pop_front(), {pulses, rsp.pslverr, irq, rsp.prdata});
            end
        end
    end

    task automatic apb(input logic wr, input logic [5:0] idx, input logic [7:0] data,
                       input logic [1:0] lo = 2'b00);
        int n;
        logic [31:0] w;
        w = xorshift();
        @(posedge clk);
        req.psel <= 1'b1;
        req.pwrite <= wr;
        req.paddr <= {idx, lo};
        req.pwdata <= {w[31:8], data};
        @(posedge clk);
        req.penable <= 1'b1;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 50);
        req.psel <= 1'b0;
        req.penable <= 1'b0;
        if (rsp.pready !== 1'b1) begin
            fail("bus answer timeout");
            stop_test();
        end
        repeat (2) @(posedge clk);
    endtask

    task automatic wr(input logic [5:0] idx, input logic [7:0] data);
        apb(1'b1, idx, data);
    endtask

    task automatic rd(input logic [5:0] idx, input logic [7:0] data,
                      input logic loose = 1'b0, input logic err = 1'b0,
                      input logic [1:0] lo = 2'b00);
        exp_q.push_back({loose, exp_pulses, err, exp_irq, 24'h0, data});
        apb(1'b0, idx, 8'h00, lo);
    endtask

    task automatic wait_clk(input int n);
        repeat (n) @(posedge clk);
    endtask

    // ****************************************************************
    // main sequence
    // ****************************************************************
    initial begin
        logic [31:0] r;
        int dv;
        int n;
        req <= '0;
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        rd(CT, 8'h40);
        rd(ST, 8'h00);
        rd(LO, 8'h00);
        rd(HI, 8'h00);
        rd(6'h05, 8'h00, 1'b0, 1'b1);
        rd(CT, 8'h00, 1'b0, 1'b1, 2'b10);
        apb(1'b1, CT, 8'h00, 2'b01);
        rd(CT, 8'h40);
        for (int i = 0; i < 4; i++) begin
            r = xorshift();
            wr(CT, {2'b01, r[5:0]});
            rd(CT, {2'b01, r[5:0]});
            irc_ir_source_i.pulse(40);
            wait_clk(20);
            rd(ST, 8'h00);
        end
        for (int k = 0; k < 4; k++) begin
            dv = (k == 0) ? 32 : 4 << (k - 1);
            wr(CT, 8'h40);
            wr(ST, 8'h01);
            wr(CT, {6'h04, k[1:0]});
            wait_clk(dv * 300 - 7);
            irc_ir_source_i.drive(1'b1);
            wait_clk(20);
            exp_pulses += 8'h01;
            exp_irq = 1'b1;
            rd(ST, 8'h03);
            rd(LO, 8'h2c, 1'b1);
            rd(HI, 8'h01);
            wr(ST, 8'h03);
            exp_irq = 1'b0;
            irc_ir_source_i.drive(1'b0);
            wait_clk(20);
            rd(ST, 8'h01);
        end
        wr(CT, 8'h31);
        wr(ST, 8'h06);
        irc_ir_source_i.drive(1'b1);
        wait_clk(399);
        irc_ir_source_i.drive(1'b0);
        wait_clk(20);
        exp_pulses += 8'h02;
        exp_irq = 1'b1;
        rd(ST, 8'h06);
        rd(LO, 8'd100, 1'b1);
        rd(HI, 8'h00);
        wr(ST, 8'h02);
        exp_pulses += 8'h01;
        rd(ST, 8'h04);
        irc_ir_source_i.drive(1'b1);
        wait_clk(199);
        irc_ir_source_i.drive(1'b0);
        wait_clk(20);
        exp_pulses += 8'h02;
        rd(ST, 8'h06);
        rd(LO, 8'd50, 1'b1);
        wr(ST, 8'h06);
        exp_irq = 1'b0;
        rd(ST, 8'h00);
        wr(LO, 8'hff);
        wr(HI, 8'hff);
        rd(LO, 8'd50, 1'b1);
        rd(HI, 8'h00);
        for (int f = 1; f < 4; f++) begin
            n = (f == 1) ? 2 : (f == 2) ? 8 : 16;
            wr(CT, {4'h3, f[1:0], 2'b01});
            irc_ir_source_i.pulse(n - 1);
            wait_clk(40);
            rd(ST, 8'h00);
            irc_ir_source_i.pulse(n);
            wait_clk(40);
            exp_pulses += 8'h02;
            exp_irq = 1'b1;
            rd(ST, 8'h06);
            wr(ST, 8'h06);
            exp_irq = 1'b0;
        end
        wr(CT, 8'h21);
        irc_ir_source_i.pulse(20);
        wait_clk(40);
        exp_pulses += 8'h01;
        exp_irq = 1'b1;
        rd(ST, 8'h04);
        wr(ST, 8'h04);
        exp_irq = 1'b0;
        wr(CT, 8'h01);
        irc_ir_source_i.pulse(20);
        wait_clk(40);
        rd(ST, 8'h00);
        stop_test();
    end

    initial begin
        repeat (60000) @(posedge clk);
        fail("run did not finish");
        stop_test();
    end
endmodule

`default_nettype wire
